// ---- common/arb_table_pkg.sv ----
package arb_table_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_VC_CONTROL = 12'h214; // control word
  localparam logic [11:0] OFS_VC_STATUS = 12'h218; // status word
  localparam logic [11:0] OFS_TABLE_WORD0 = 12'h220; // phase slots 0..7

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_COHERENCY = 16; // table_coherency_flag in status
  localparam int BIT_FC_PENDING = 17; // fc_init_pending in status
  localparam int BIT_LOAD_REQ = 16; // table_load_request in control
  localparam int SEL_LSB = 17; // arbitration select low bit
  localparam int SEL_W = 3; // arbitration select width

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic [31:0] RST_TABLE_WORD = 32'h0000_0000;
  localparam logic [2:0] RST_ARB_SELECT = 3'h0;
  // select codes whose scheme reads the programmable table
  localparam logic [7:0] TABLE_SCHEME_MASK = 8'hFE;

  // ---------------------------------------------------------------
  // phase slot layout and port codes
  // ---------------------------------------------------------------
  localparam int NUM_SLOTS = 8;
  localparam int SLOT_W = 4;
  localparam logic [3:0] PORT_UP0 = 4'h0; // upstream port 0
  localparam logic [3:0] PORT_2 = 4'h2;
  localparam logic [3:0] PORT_4 = 4'h4;

  // ---------------------------------------------------------------
  // ahb-lite encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

endpackage : arb_table_pkg

// ---- design/phase_walker.sv ----
`timescale 1ns/1ps

// ---------------------------------------------------------------
// arbiter side: shadow copy of the phase table and phase walker
// ---------------------------------------------------------------
module phase_walker
  import arb_table_pkg::*;
#(
  parameter int SLOTS = NUM_SLOTS,
  parameter logic [3:0] EGRESS_PORT = PORT_UP0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // load control
  input wire logic load_start,
  input wire logic [SLOTS*SLOT_W-1:0] table_word,
  output logic load_busy,
  output logic load_done,
  // grant
  output logic grant_valid,
  output logic [SLOT_W-1:0] grant_port,
  output logic [2:0] grant_phase
);

  logic [SLOT_W-1:0] shadow [SLOTS]; // slots latched by the arbiter
  logic [2:0] load_idx; // slot being copied
  logic [2:0] ptr; // phase to look at next
  logic [SLOTS-1:0] slot_ok; // slot names a legal target
  logic found; // some legal phase exists
  logic [2:0] pick; // first legal phase at or after ptr

  // legal codes: 0, 2, 4, never the egress port itself
  generate
    for (genvar i = 0; i < SLOTS; i++) begin : g_ok
      assign slot_ok[i] = (shadow[i] == PORT_UP0 || shadow[i] == PORT_2 || shadow[i] == PORT_4)
                          && shadow[i] != EGRESS_PORT;
    end
  endgenerate

  // scan ahead so a bad slot costs no cycle
  always_comb begin
    logic [2:0] idx;
    idx = 3'h0;
    found = 1'b0;
    pick = ptr;
    for (int k = SLOTS - 1; k >= 0; k--) begin
      idx = ptr + 3'(k);
      if (slot_ok[idx]) begin
        found = 1'b1;
        pick = idx;
      end
    end
  end

  // copy one slot per cycle; walking pauses meanwhile
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      load_busy <= 1'b0;
      load_done <= 1'b0;
      load_idx <= 3'h0;
      for (int i = 0; i < SLOTS; i++) begin
        shadow[i] <= '0;
      end
    end else begin
      load_done <= 1'b0;
      if (load_busy) begin
        shadow[load_idx] <= table_word[load_idx*SLOT_W +: SLOT_W];
        load_idx <= load_idx + 3'h1;
        if (load_idx == 3'(SLOTS - 1)) begin
          load_busy <= 1'b0;
          load_done <= 1'b1;
        end
      end else if (load_start) begin
        load_busy <= 1'b1;
        load_idx <= 3'h0;
      end
    end
  end

  // one granted phase per cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ptr <= 3'h0;
      grant_valid <= 1'b0;
      grant_port <= '0;
      grant_phase <= 3'h0;
    end else begin
      grant_valid <= found && !load_busy;
      if (found && !load_busy) begin
        grant_port <= shadow[pick];
        grant_phase <= pick;
        ptr <= pick + 3'h1;
      end
    end
  end

  chk_grant_legal_code: assert property (@(posedge sys_clk) disable iff (!rstn)
    grant_valid |-> (grant_port == PORT_UP0 || grant_port == PORT_2 || grant_port == PORT_4))
    else $error("grant names a reserved port code");

  chk_skip_no_delay: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!load_busy && found) |=> (grant_valid && grant_phase == $past(pick)))
    else $error("legal phase not granted in the next cycle");

endmodule : phase_walker

// ---- design/arb_table_status.sv ----
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps

// Notes on behaviour
// - any table write sets the coherency flag
// - flag shown only when scheme uses table
// - downstream instance always reads flag as zero
// - bit 17 mirrors flow-control init pending
// - eight 4-bit phase slots, reset to zero
// - invalid slot skipped without any delay
// - codes 0, 2, 4 legal; rest reserved; the walker also skips the egress port's own code (code 0 by default)
// - load request reads zero; one triggers load
// - load request acts only in upstream instance

module arb_table_status
  import arb_table_pkg::*;
#(
  parameter logic [3:0] EGRESS_PORT = PORT_UP0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // switch context
  input wire logic is_upstream,
  input wire logic fc_init_pending,
  // arbiter grant
  output logic grant_valid,
  output logic [3:0] grant_port,
  output logic [2:0] grant_phase
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [31:0] arbitration_phase_table_word0; // eight phase slots
  logic [2:0] arb_select; // arbitration scheme select
  logic coherency; // raw table_coherency_flag
  logic dp_write; // data phase of a write pending
  logic [11:0] dp_addr; // address of that write
  logic addr_take; // address phase accepted
  logic wr_table; // table word written this cycle
  logic wr_ctl; // control word written this cycle
  logic load_start; // launch of a table load
  logic load_busy; // arbiter still copying
  logic load_done; // copy finished, one cycle
  logic uses_table; // selected scheme reads the table
  logic [31:0] status_view; // status word as software sees it
  logic [31:0] ctl_view; // control word as software sees it
  logic [31:0] next_rdata; // read mux output

  // ---------------------------------------------------------------
  // bus front end
  // ---------------------------------------------------------------

  // no wait states ever, so the slave never stretches a transfer
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign addr_take = hsel && hready && htrans == HTRANS_NONSEQ;

  // only word transfers are used; hsize is accepted and not checked
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dp_write <= 1'b0;
      dp_addr <= 12'h000;
    end else if (hready) begin
      dp_write <= addr_take && hwrite;
      dp_addr <= haddr;
    end
  end

  // writes land in the data phase, when hwdata stands
  assign wr_table = dp_write && dp_addr == OFS_TABLE_WORD0;
  assign wr_ctl = dp_write && dp_addr == OFS_VC_CONTROL;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------

  // phase slots
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      arbitration_phase_table_word0 <= RST_TABLE_WORD;
    end else if (wr_table) begin
      arbitration_phase_table_word0 <= hwdata;
    end
  end

  // scheme select; the load bit itself is not stored
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      arb_select <= RST_ARB_SELECT;
    end else if (wr_ctl) begin
      arb_select <= hwdata[SEL_LSB +: SEL_W];
    end
  end

  // writing one starts a load, zero does nothing; downstream ignores it
  assign load_start = wr_ctl && hwdata[BIT_LOAD_REQ] && is_upstream;

  // set wins over the clearing done pulse, so a late write stays flagged
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      coherency <= 1'b0;
    end else if (wr_table) begin
      coherency <= 1'b1;
    end else if (load_done) begin
      coherency <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // read side
  // ---------------------------------------------------------------
  assign uses_table = TABLE_SCHEME_MASK[arb_select];

  // reserved bits are constant zero, writes to status go nowhere
  // a read taken in a write's data phase already sees the flag that write sets
  always_comb begin
    status_view = 32'h0000_0000;
    status_view[BIT_COHERENCY] = (coherency || wr_table) && uses_table && is_upstream;
    status_view[BIT_FC_PENDING] = fc_init_pending;
  end

  // load request bit is never stored, so it always reads zero
  always_comb begin
    ctl_view = 32'h0000_0000;
    ctl_view[SEL_LSB +: SEL_W] = wr_ctl ? hwdata[SEL_LSB +: SEL_W] : arb_select;
  end

  // unmapped addresses read zero; a pipelined read forwards the write in flight
  always_comb begin
    unique case (haddr)
      OFS_VC_CONTROL: next_rdata = ctl_view;
      OFS_VC_STATUS: next_rdata = status_view;
      OFS_TABLE_WORD0: next_rdata = wr_table ? hwdata : arbitration_phase_table_word0;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // sampled at the address phase, held through the data phase
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_take && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // arbiter
  // ---------------------------------------------------------------
  phase_walker #(
    .SLOTS(NUM_SLOTS),
    .EGRESS_PORT(EGRESS_PORT)
  ) u_walker (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .load_start(load_start),
    .table_word(arbitration_phase_table_word0),
    .load_busy(load_busy),
    .load_done(load_done),
    .grant_valid(grant_valid),
    .grant_port(grant_port),
    .grant_phase(grant_phase)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_coh_set_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_table |=> coherency)
    else $error("table write did not set coherency");

  chk_coh_clear_load: assert property (@(posedge sys_clk) disable iff (!rstn)
    (load_done && !wr_table) |=> !coherency)
    else $error("coherency not cleared after load");

  chk_coh_hold_pending: assert property (@(posedge sys_clk) disable iff (!rstn)
    (coherency && !load_done) |=> coherency)
    else $error("coherency dropped before load finished");

  chk_coh_scheme_gate: assert property (@(posedge sys_clk) disable iff (!rstn)
    (addr_take && !hwrite && haddr == OFS_VC_STATUS && !uses_table) |=> !hrdata[BIT_COHERENCY])
    else $error("coherency shown for non-table scheme");

  chk_coh_downstream_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
    (addr_take && !hwrite && haddr == OFS_VC_STATUS && !is_upstream) |=> !hrdata[BIT_COHERENCY])
    else $error("downstream coherency not zero");

  chk_fc_pending_bit: assert property (@(posedge sys_clk) disable iff (!rstn)
    (addr_take && !hwrite && haddr == OFS_VC_STATUS) |=> hrdata[BIT_FC_PENDING] == $past(fc_init_pending))
    else $error("fc pending bit wrong on read");

  chk_table_write_data: assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_table |=> arbitration_phase_table_word0 == $past(hwdata))
    else $error("table word not updated");

  chk_load_reads_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
    (addr_take && !hwrite && haddr == OFS_VC_CONTROL) |=> !hrdata[BIT_LOAD_REQ])
    else $error("load request read back nonzero");

  chk_load_upstream_only: assert property (@(posedge sys_clk) disable iff (!rstn)
    (wr_ctl && hwdata[BIT_LOAD_REQ] && !is_upstream && !load_busy) |=> !load_busy)
    else $error("downstream load request took effect");

  chk_load_upstream_go: assert property (@(posedge sys_clk) disable iff (!rstn)
    (load_start && !load_busy) |=> load_busy ##8 load_done)
    else $error("load did not run eight cycles");

  chk_status_reserved: assert property (@(posedge sys_clk) disable iff (!rstn)
    (addr_take && !hwrite && haddr == OFS_VC_STATUS) |=> (hrdata[15:0] == 16'h0000 && hrdata[31:18] == 14'h0000))
    else $error("status reserved bits nonzero");

endmodule : arb_table_status

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps

// ---------------------------------------------------------------
// self-checking bench: phase table, status and grant walker
// ---------------------------------------------------------------
module tb_top import arb_table_pkg::*; ;
  // clock, reset and bus
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  // switch context and grant outputs
  logic is_upstream = 1'b1;
  logic fc_init_pending = 1'b0;
  logic grant_valid;
  logic [3:0] grant_port;
  logic [2:0] grant_phase;
  // bookkeeping
  int n_errors = 0;
  int compares = 0;
  integer seed = 32;
  logic [31:0] rd;
  logic [31:0] tbl;
  logic [31:0] corner [3] = '{32'h4444_4444, 32'hF2FF_FFFF, 32'h3535_1F1F};

  // one slave, so its ready is the bus ready
  assign hready = hreadyout;

  arb_table_status u_arb_table_status (
    .sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .is_upstream(is_upstream),
    .fc_init_pending(fc_init_pending), .grant_valid(grant_valid),
    .grant_port(grant_port), .grant_phase(grant_phase)
  );

  // free-running 100 MHz clock
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task automatic end_sim;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      n_errors++;
    end
  endtask : check

  // only codes 2 and 4 are grantable; code 0 is the egress port here
  function automatic bit legal(input logic [3:0] c);
    return c == PORT_2 || c == PORT_4;
  endfunction : legal

  // first legal phase after ph, wrapping; illegal phases cost nothing
  function automatic logic [2:0] next_legal(input logic [31:0] t, input logic [2:0] ph);
    logic [2:0] p;
    for (int i = 1; i <= 8; i++) begin
      p = 3'(ph + i);
      if (legal(t[p*4 +: 4])) return p;
    end
    return ph;
  endfunction : next_legal

  // random table of grantable codes only, so software keeps off reserved and egress codes
  function automatic logic [31:0] legal_table(input logic [31:0] r);
    logic [31:0] t;
    for (int i = 0; i < 8; i++) t[i*4 +: 4] = r[i] ? PORT_4 : PORT_2;
    return t;
  endfunction : legal_table

  // ---------------------------------------------------------------
  // ahb-lite master
  // ---------------------------------------------------------------
  // bounded wait for hready at a rising edge
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        n_errors++;
        end_sim();
      end
      @(posedge sys_clk);
    end
  endtask : wait_ready

  task automatic ahb_xfer(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= 3'h2;
    wait_ready();
    // data phase: address released, write data held to the next ready
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_ready();
    r = hrdata;
    check({31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask : ahb_xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    ahb_xfer(a, 1'b1, d, dummy);
  endtask : wr

  task automatic rd_check(input logic [11:0] a, input logic [31:0] exp);
    ahb_xfer(a, 1'b0, 32'h0000_0000, rd);
    check(rd, exp);
  endtask : rd_check

  // poll the coherency flag until the arbiter has taken the table
  task automatic wait_clear;
    int n;
    n = 0;
    rd = 32'h0001_0000;
    while (rd[BIT_COHERENCY] !== 1'b0) begin
      if (n == 40) begin
        n_errors++;
        end_sim();
      end
      ahb_xfer(OFS_VC_STATUS, 1'b0, 32'h0000_0000, rd);
      n++;
    end
  endtask : wait_clear

  // every cycle a legal slot must be granted, in table order
  task automatic watch_grants(input logic [31:0] t, input int cycles);
    bit any;
    bit first;
    logic [2:0] prev;
    any = 0;
    first = 1;
    for (int i = 0; i < 8; i++) any |= legal(t[i*4 +: 4]);
    repeat (cycles) begin
      @(posedge sys_clk);
      #1;
      check({31'h0, grant_valid}, {31'h0, any});
      if (any && grant_valid === 1'b1) begin
        check({28'h0, grant_port}, {28'h0, t[grant_phase*4 +: 4]});
        if (!first) check({29'h0, grant_phase}, {29'h0, next_legal(t, prev)});
        prev = grant_phase;
        first = 0;
      end
    end
  endtask : watch_grants

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    watch_grants(32'h0000_0000, 10);
    rd_check(OFS_VC_STATUS, 32'h0000_0000);
    rd_check(OFS_TABLE_WORD0, RST_TABLE_WORD);
    rd_check(OFS_VC_CONTROL, 32'h0000_0000);
    rd_check(12'h300, 32'h0000_0000);
    wr(OFS_VC_STATUS, 32'hFFFF_FFFF);
    rd_check(OFS_VC_STATUS, 32'h0000_0000);
    tbl = $random(seed);
    wr(OFS_TABLE_WORD0, tbl);
    rd_check(OFS_TABLE_WORD0, tbl);
    rd_check(OFS_VC_STATUS, 32'h0000_0000);
    @(posedge sys_clk);
    fc_init_pending <= 1'b1;
    rd_check(OFS_VC_STATUS, 32'h0002_0000);
    fc_init_pending <= 1'b0;
    // select a table scheme: the earlier write now shows
    wr(OFS_VC_CONTROL, 32'h0002_0000);
    rd_check(OFS_VC_CONTROL, 32'h0002_0000);
    rd_check(OFS_VC_STATUS, 32'h0001_0000);
    // hand-written corners exercise the skip path; random tables keep to legal codes
    for (int k = 0; k < 8; k++) begin
      tbl = (k < 3) ? corner[k] : legal_table($random(seed));
      wr(OFS_TABLE_WORD0, tbl);
      rd_check(OFS_TABLE_WORD0, tbl);
      rd_check(OFS_VC_STATUS, 32'h0001_0000);
      wr(OFS_VC_CONTROL, 32'h0003_0000);
      rd_check(OFS_VC_CONTROL, 32'h0002_0000);
      wait_clear();
      watch_grants(tbl, 20);
    end
    // downstream instance: flag hidden, load ignored
    @(posedge sys_clk);
    is_upstream <= 1'b0;
    wr(OFS_TABLE_WORD0, 32'h2424_2424);
    rd_check(OFS_VC_STATUS, 32'h0000_0000);
    wr(OFS_VC_CONTROL, 32'h0003_0000);
    repeat (12) @(posedge sys_clk);
    is_upstream <= 1'b1;
    rd_check(OFS_VC_STATUS, 32'h0001_0000);
    wr(OFS_VC_CONTROL, 32'h0003_0000);
    wait_clear();
    watch_grants(32'h2424_2424, 20);
    end_sim();
  end
endmodule : tb_top
